/* rtl/rca_top.sv */
// rc oscillation converter: counters, control registers and apb slave
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "rca_params.svh"
// Function
// - reference counter is a decade counter of system clocks, max 79999.
// - oscillation counter is a 14-bit binary counter of oscillation clocks, max 16383.
// - each counter owns an overflow flag able to raise the converter interrupt.
// - source select bit 1: zero picks reference overflow, one oscillation overflow.
// - the converter interrupt is served at vector 02FH.
// - enable bit clear keeps oscillator stopped and both counters still.
// - setting enable starts the oscillator and counting of both clocks.
// - modes 1 to 4 pick one resistor or capacitor pair, complementary drive; modes 5 and 6 drive one channel 1 resistor pin.
// - modes 0 and 7 stop oscillation and count external input 0 or 1.
// - undriven pins float; top mode bit set floats every pin.
// - at most one oscillation channel runs at any time.
// - a test mode routes the oscillation clock to the monitor pin.
// - counting starts only after the synchronised run signal follows enable.
// - gate overflow clears enable, stops both counters and sets the done flag, which raises the interrupt if its mask bit is set.
module rca_top
   import rca_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             conv_done_irq,
   input  wire logic        ch0_ext_clock_in,
   input  wire logic        ch1_ext_clock_in,
   output logic             ch0_ref_resistor_pin_o,
   output logic             ch0_ref_resistor_pin_oe,
   output logic             ch0_sensor_resistor_pin_o,
   output logic             ch0_sensor_resistor_pin_oe,
   output logic             ch0_second_ref_pin_o,
   output logic             ch0_second_ref_pin_oe,
   output logic             ch0_ref_cap_pin_o,
   output logic             ch0_ref_cap_pin_oe,
   output logic             ch1_ref_resistor_pin_o,
   output logic             ch1_ref_resistor_pin_oe,
   output logic             ch1_sensor_resistor_pin_o,
   output logic             ch1_sensor_resistor_pin_oe,
   output logic             osc_monitor_pin
);
   localparam rca_top_s ST_RST = '{
      conv_enable    : `RCA_RST_EN,
      irq_source_sel : `RCA_RST_SRC,
      osc_mode_field : `RCA_RST_MODE,
      ref_counter    : `RCA_RST_REF,
      osc_counter    : `RCA_RST_OSC,
      mask           : `RCA_RST_MASK,
      default        : '0
   };

   rca_top_s    st_r;
   rca_top_s    st_nxt;
   logic        setup;
   logic        wr;
   logic        wr_run;
   logic        wr_mode;
   logic        wr_ref;
   logic        wr_osc;
   logic        wr_sts;
   logic        wr_mask;
   logic        wr_test;
   logic        counting;
   logic        osc_tick;
   logic        osc_level;
   logic [5:0]  osc_o;
   logic [5:0]  osc_oe;
   logic [5:0]  carry;
   logic [19:0] ref_inc;
   logic        ref_ovf;
   logic        osc_ovf;
   logic        gate_ovf;
   logic [2:0]  sts_set;
   logic [31:0] rd_data;
   logic        rd_err;

   // ----------------------------------------
   // apb decode
   // ----------------------------------------
   assign setup   = psel & ~penable;
   assign wr      = psel & penable & pwrite & ~st_r.slverr;
   assign wr_run  = wr & (paddr == `RCA_OFS_RUN);
   assign wr_mode = wr & (paddr == `RCA_OFS_MODE);
   assign wr_ref  = wr & (paddr == `RCA_OFS_REF);
   assign wr_osc  = wr & (paddr == `RCA_OFS_OSC);
   assign wr_sts  = wr & (paddr == `RCA_OFS_STS);
   assign wr_mask = wr & (paddr == `RCA_OFS_MASK);
   assign wr_test = wr & (paddr == `RCA_OFS_TEST);

   always_comb
   begin
      rd_data = 32'h0000_0000;
      rd_err  = 1'b0;
      case (paddr)
         `RCA_OFS_RUN  : rd_data[1:0]  = {st_r.irq_source_sel, st_r.conv_enable};
         `RCA_OFS_MODE : rd_data[3:0]  = st_r.osc_mode_field;
         `RCA_OFS_REF  : rd_data[19:0] = st_r.ref_counter;
         `RCA_OFS_OSC  : rd_data[13:0] = st_r.osc_counter;
         `RCA_OFS_STS  : rd_data[2:0]  = st_r.sts;
         `RCA_OFS_MASK : rd_data[2:0]  = st_r.mask;
         `RCA_OFS_TEST : rd_data[0]    = st_r.mon_en;
         `RCA_OFS_INFO : rd_data[11:0] = `RCA_IRQ_VECTOR;
         default       : rd_err        = 1'b1;
      endcase
   end

   // ----------------------------------------
   // counters
   // ----------------------------------------
   // both counters advance only while enabled and synchronised
   assign counting = st_r.conv_enable & st_r.count_run_sync;

   // decade chain: four digits to 9, top digit to 7
   assign carry[0] = 1'b1;
   for (genvar d = 0; d < 5; d++)
   begin : g_dig
      localparam logic [3:0] DMAX = (d == 4) ? `RCA_TOP_MAX : `RCA_DEC_MAX;
      logic [3:0] dig;
      logic       at_max;
      assign dig    = st_r.ref_counter[4*d +: 4];
      assign at_max = (dig == DMAX);
      assign ref_inc[4*d +: 4] = !carry[d] ? dig : (at_max ? 4'h0 : dig + 4'h1);
      assign carry[d+1] = carry[d] & at_max;
   end

   assign ref_ovf  = counting & carry[5];
   assign osc_ovf  = counting & osc_tick & (st_r.osc_counter == `RCA_OSC_MAX);
   assign gate_ovf = st_r.irq_source_sel ? osc_ovf : ref_ovf;
   assign sts_set  = {osc_ovf, ref_ovf, gate_ovf};

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      st_nxt = st_r;
      if (counting)
      begin
         st_nxt.ref_counter = ref_inc;
         if (osc_tick)
            st_nxt.osc_counter = st_r.osc_counter + 14'h0001;
      end
      if (gate_ovf)
         st_nxt.conv_enable = 1'b0;
      // run follows enable one cycle late and drops at once on overflow
      st_nxt.count_run_sync = st_r.conv_enable & ~gate_ovf;
      // a new event wins over a write-one clear
      st_nxt.sts = (st_r.sts & ~(wr_sts ? pwdata[2:0] : 3'h0)) | sts_set;
      st_nxt.mon_out = st_r.mon_en & osc_level;
      if (wr_run)
      begin
         st_nxt.conv_enable    = pwdata[`RCA_BIT_EN];
         st_nxt.irq_source_sel = pwdata[`RCA_BIT_SRC];
      end
      if (wr_mode)
         st_nxt.osc_mode_field = pwdata[3:0];
      if (wr_ref)
         st_nxt.ref_counter = pwdata[19:0];
      if (wr_osc)
         st_nxt.osc_counter = pwdata[13:0];
      if (wr_mask)
         st_nxt.mask = pwdata[2:0];
      if (wr_test)
         st_nxt.mon_en = pwdata[`RCA_BIT_MON];
      if (setup)
      begin
         st_nxt.prdata = rd_data;
         st_nxt.slverr = rd_err;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         st_r <= ST_RST;
      else
         st_r <= st_nxt;
   end

   // ----------------------------------------
   // oscillator
   // ----------------------------------------
   rca_osc u_osc
   (
      .clock     (clock),
      .rstn      (rstn),
      .mode      (st_r.osc_mode_field),
      .run       (counting),
      .ext0_in   (ch0_ext_clock_in),
      .ext1_in   (ch1_ext_clock_in),
      .osc_tick  (osc_tick),
      .osc_level (osc_level),
      .pin_o     (osc_o),
      .pin_oe    (osc_oe)
   );

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign prdata        = st_r.prdata;
   assign pready        = 1'b1;
   assign pslverr       = psel & penable & st_r.slverr;
   assign conv_done_irq = |(st_r.sts & st_r.mask);
   assign osc_monitor_pin = st_r.mon_out;

   assign ch0_ref_resistor_pin_o     = osc_o[0];
   assign ch0_ref_resistor_pin_oe    = osc_oe[0];
   assign ch0_sensor_resistor_pin_o  = osc_o[1];
   assign ch0_sensor_resistor_pin_oe = osc_oe[1];
   assign ch0_second_ref_pin_o       = osc_o[2];
   assign ch0_second_ref_pin_oe      = osc_oe[2];
   assign ch0_ref_cap_pin_o          = osc_o[3];
   assign ch0_ref_cap_pin_oe         = osc_oe[3];
   assign ch1_ref_resistor_pin_o     = osc_o[4];
   assign ch1_ref_resistor_pin_oe    = osc_oe[4];
   assign ch1_sensor_resistor_pin_o  = osc_o[5];
   assign ch1_sensor_resistor_pin_oe = osc_oe[5];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_start;
      !st_r.conv_enable ##1 st_r.conv_enable;
   endsequence

   sequence s_stopped;
      !st_r.conv_enable && !st_r.count_run_sync && st_r.sts[`RCA_STS_DONE]
         && (conv_done_irq || !st_r.mask[`RCA_STS_DONE]) ##1 !st_r.count_run_sync;
   endsequence

   a_ref_wrap: assert property (
      (counting && !wr && st_r.ref_counter == `RCA_REF_MAX)
      |=> (st_r.ref_counter == 20'h00000) && st_r.sts[`RCA_STS_REF])
      else $error("reference counter did not wrap at its maximum");

   a_osc_step: assert property (
      (counting && osc_tick && !wr)
      |=> st_r.osc_counter == 14'($past(st_r.osc_counter) + 14'h0001))
      else $error("oscillation counter did not advance by one");

   a_osc_flag: assert property (
      (osc_ovf && !wr) |=> st_r.sts[`RCA_STS_OSC] && (st_r.osc_counter == 14'h0000))
      else $error("oscillation overflow flag not set");

   a_ref_gate: assert property (
      (counting && !wr && !st_r.irq_source_sel && st_r.ref_counter == `RCA_REF_MAX)
      |=> !st_r.conv_enable && st_r.sts[`RCA_STS_DONE])
      else $error("reference overflow did not end conversion");

   a_halt_frozen: assert property (
      (!st_r.conv_enable && !wr) |=> $stable(st_r.ref_counter) && $stable(st_r.osc_counter))
      else $error("counter moved while halted");

   a_start_run: assert property (
      s_start |-> !st_r.count_run_sync ##1 st_r.count_run_sync)
      else $error("run signal did not follow enable");

   a_gate_stop: assert property (
      (gate_ovf && !wr) |=> s_stopped)
      else $error("gate overflow did not stop conversion");

   a_pins_float: assert property (
      st_r.osc_mode_field[`RCA_BIT_TOP] && !wr |=> osc_oe == 6'h00)
      else $error("pin driven with top mode bit set");

   a_one_chan: assert property (
      !((|osc_oe[3:0]) && (|osc_oe[5:4])))
      else $error("both oscillation channels driven");

   a_monitor: assert property (
      (st_r.mon_en && osc_level && !wr) |=> osc_monitor_pin)
      else $error("monitor pin missed oscillation level");

   a_halt_pins: assert property (
      !st_r.conv_enable |=> osc_oe == 6'h00)
      else $error("pin driven while conversion halted");

   a_ext_float: assert property (
      (st_r.osc_mode_field == 4'h0 || st_r.osc_mode_field == 4'h7) |=> osc_oe == 6'h00)
      else $error("pin driven in external clock mode");

   a_chan0_pair: assert property (
      (counting && st_r.osc_mode_field inside {4'h1, 4'h2, 4'h3, 4'h4})
      |=> ($countones(osc_oe) == 2) && (osc_oe[5:4] == 2'b00))
      else $error("channel 0 mode did not drive one pin pair");

   a_chan1_single: assert property (
      (counting && st_r.osc_mode_field inside {4'h5, 4'h6})
      |=> ($countones(osc_oe) == 1) && (osc_oe[3:0] == 4'h0))
      else $error("channel 1 mode drove a wrong pin");

   a_pair_compl: assert property (
      ($countones(osc_oe) == 2) |-> ($countones(osc_o & osc_oe) == 1))
      else $error("driven pin pair not complementary");

   a_osc_hold: assert property (
      (counting && !osc_tick && !wr) |=> $stable(st_r.osc_counter))
      else $error("oscillation counter moved without a tick");

   a_dec_step: assert property (
      (counting && !wr && st_r.ref_counter[3:0] < 4'h9)
      |=> st_r.ref_counter[3:0] == 4'($past(st_r.ref_counter[3:0]) + 4'h1))
      else $error("reference digit did not advance by one");

   a_dec_wrap: assert property (
      (counting && !wr && st_r.ref_counter[3:0] == 4'h9) |=> st_r.ref_counter[3:0] == 4'h0)
      else $error("reference digit did not wrap after nine");

   a_side_ovf: assert property (
      (osc_ovf && !ref_ovf && !st_r.irq_source_sel && !wr) |=> st_r.conv_enable && st_r.count_run_sync)
      else $error("non-selected overflow ended the conversion");

   a_sync_follow: assert property (
      !st_r.conv_enable |=> !st_r.count_run_sync)
      else $error("run signal stayed up without enable");

   a_sts_sticky: assert property (
      !wr_sts |=> (st_r.sts & $past(st_r.sts)) == $past(st_r.sts))
      else $error("status bit lost without a clear");

   a_done_clear: assert property (
      (wr_sts && pwdata[`RCA_STS_DONE] && !gate_ovf) |=> !st_r.sts[`RCA_STS_DONE])
      else $error("done flag not cleared by writing one");

   a_vector_read: assert property (
      (setup && paddr == `RCA_OFS_INFO) |=> prdata[11:0] == `RCA_IRQ_VECTOR)
      else $error("interrupt vector read wrong");

   a_monitor_off: assert property (
      !st_r.mon_en |=> !osc_monitor_pin)
      else $error("monitor pin active while disabled");
endmodule : rca_top
`default_nettype wire

/* rtl/rca_params.svh */
// register map, field positions, reset values and limits of the rc converter
`ifndef RCA_PARAMS_SVH
`define RCA_PARAMS_SVH
`define RCA_OFS_RUN    8'h00
`define RCA_OFS_MODE   8'h04
`define RCA_OFS_REF    8'h08
`define RCA_OFS_OSC    8'h0C
`define RCA_OFS_STS    8'h10
`define RCA_OFS_MASK   8'h14
`define RCA_OFS_TEST   8'h18
`define RCA_OFS_INFO   8'h1C
`define RCA_BIT_EN     0
`define RCA_BIT_SRC    1
`define RCA_BIT_MON    0
`define RCA_BIT_TOP    3
`define RCA_STS_DONE   0
`define RCA_STS_REF    1
`define RCA_STS_OSC    2
`define RCA_RST_EN     1'h0
`define RCA_RST_SRC    1'h0
`define RCA_RST_MODE   4'h0
`define RCA_RST_REF    20'h00000
`define RCA_RST_OSC    14'h0000
`define RCA_RST_MASK   3'h0
`define RCA_DEC_MAX    4'h9
`define RCA_TOP_MAX    4'h7
`define RCA_REF_MAX    20'h79999
`define RCA_OSC_MAX    14'h3FFF
`define RCA_IRQ_VECTOR 12'h02F
`define RCA_DRV_RS0    16'h0012
`define RCA_DRV_RT0    16'h0004
`define RCA_DRV_CH0_SECOND_REF_PIN   16'h0018
`define RCA_DRV_CS0    16'h000E
`define RCA_DRV_RS1    16'h0020
`define RCA_DRV_RT1    16'h0040
`define RCA_INV_CH0_SECOND_REF_PIN   16'h0010
`define RCA_INV_CS0    16'h000E
`endif

/* rtl/rca_pkg.sv */
// shared types of the rc converter
`default_nettype none
package rca_pkg;
   typedef logic [3:0] rca_mode_t;
   typedef struct packed {
      logic        conv_enable;
      logic        irq_source_sel;
      logic        count_run_sync;
      rca_mode_t   osc_mode_field;
      logic [19:0] ref_counter;
      logic [13:0] osc_counter;
      logic [2:0]  sts;
      logic [2:0]  mask;
      logic        mon_en;
      logic        mon_out;
      logic [31:0] prdata;
      logic        slverr;
   } rca_top_s;
   typedef struct packed {
      logic [1:0]  sync0;
      logic [1:0]  sync1;
      logic        prev;
      logic        tick;
      logic [5:0]  pin_o;
      logic [5:0]  pin_oe;
   } rca_osc_s;
endpackage : rca_pkg
`default_nettype wire

/* rtl/rca_osc.sv */
// rc oscillator pin driver and oscillation clock recovery
`timescale 1ns/10ps
`default_nettype none
`include "rca_params.svh"
module rca_osc
   import rca_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rstn,
   input  wire rca_mode_t  mode,
   input  wire logic       run,
   input  wire logic       ext0_in,
   input  wire logic       ext1_in,
   output logic            osc_tick,
   output logic            osc_level,
   output logic [5:0]      pin_o,
   output logic [5:0]      pin_oe
);
   // pins: rs0, rt0, ch0_second_ref_pin, cs0, rs1, rt1
   localparam logic [15:0] DRV [6] = '{`RCA_DRV_RS0, `RCA_DRV_RT0, `RCA_DRV_CH0_SECOND_REF_PIN,
                                       `RCA_DRV_CS0, `RCA_DRV_RS1, `RCA_DRV_RT1};
   localparam logic [15:0] INV [6] = '{16'h0000, 16'h0000, `RCA_INV_CH0_SECOND_REF_PIN,
                                       `RCA_INV_CS0, 16'h0000, 16'h0000};

   rca_osc_s   st_r;
   rca_osc_s   st_nxt;
   logic       ch1;
   logic       lvl;
   logic [5:0] oe_w;
   logic [5:0] o_w;

   // ----------------------------------------
   // channel choice and pin table
   // ----------------------------------------
   // modes 5 to 7 use channel 1, lower ones channel 0, never both
   assign ch1 = ~mode[`RCA_BIT_TOP] & mode[2] & (mode[1] | mode[0]);
   // top mode bit silences the counted source
   assign lvl = mode[`RCA_BIT_TOP] ? 1'b0 : (ch1 ? st_r.sync1[1] : st_r.sync0[1]);

   for (genvar i = 0; i < 6; i++)
   begin : g_pin
      assign oe_w[i] = run & DRV[i][mode];
      assign o_w[i]  = INV[i][mode] ? lvl : ~lvl;
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   always_comb
   begin
      st_nxt        = st_r;
      st_nxt.sync0  = {st_r.sync0[0], ext0_in};
      st_nxt.sync1  = {st_r.sync1[0], ext1_in};
      st_nxt.prev   = lvl;
      st_nxt.tick   = run & lvl & ~st_r.prev;
      st_nxt.pin_o  = o_w;
      st_nxt.pin_oe = oe_w;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign osc_tick  = st_r.tick;
   assign osc_level = st_r.prev;
   assign pin_o     = st_r.pin_o;
   assign pin_oe    = st_r.pin_oe;
endmodule : rca_osc
`default_nettype wire

/* tb/rca_rc_model.sv */
// rc network and external clock source feeding the sense inputs
`timescale 1ns/10ps
`default_nettype none
module rca_rc_model #(
   parameter int HALF = 4
) (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic run0,
   input  wire logic run1,
   output logic      sense0,
   output logic      sense1
);
   int cnt;
   // --------
   // oscillation
   // --------
   // an undriven network discharges, so the sense level settles low
   always @(posedge clock or negedge rstn)
   begin
      if (!rstn || !(run0 || run1))
      begin
         cnt <= 0;
         sense0 <= 1'b0;
         sense1 <= 1'b0;
      end
      else if (cnt == HALF - 1)
      begin
         cnt <= 0;
         sense0 <= run0 & ~sense0;
         sense1 <= run1 & ~sense1;
      end
      else
         cnt <= cnt + 1;
   end
endmodule : rca_rc_model
`default_nettype wire

/* tb/rca_top_tb.sv */
// self-checking bench of the rc oscillation converter
`timescale 1ns/10ps
`default_nettype none
`include "rca_params.svh"
module rca_top_tb;
   // --------
   // signals
   // --------
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic        ext0 = 1'b0;
   logic        ext1 = 1'b0;
   logic [31:0] prdata, q;
   logic [5:0]  po, oe;
   logic        pready, pslverr, irq, s0, s1, mon, e;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          ncyc = 0;
   int          mon_rises = 0;
   localparam logic [5:0] xoe_tab [10] = '{6'h00, 6'h24, 6'h14, 6'h0C, 6'h28, 6'h02, 6'h01, 6'h00, 6'h00, 6'h00};

   initial forever #2 clock = ~clock;
   always @(posedge mon) mon_rises++;

   rca_top u_dut (
      .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done_irq(irq),
      .ch0_ext_clock_in(s0), .ch1_ext_clock_in(s1),
      .ch0_ref_resistor_pin_o(po[5]), .ch0_ref_resistor_pin_oe(oe[5]),
      .ch0_sensor_resistor_pin_o(po[4]), .ch0_sensor_resistor_pin_oe(oe[4]),
      .ch0_second_ref_pin_o(po[3]), .ch0_second_ref_pin_oe(oe[3]),
      .ch0_ref_cap_pin_o(po[2]), .ch0_ref_cap_pin_oe(oe[2]),
      .ch1_ref_resistor_pin_o(po[1]), .ch1_ref_resistor_pin_oe(oe[1]),
      .ch1_sensor_resistor_pin_o(po[0]), .ch1_sensor_resistor_pin_oe(oe[0]),
      .osc_monitor_pin(mon));

   rca_rc_model u_rc (
      .clock(clock), .rstn(rstn), .run0((|oe[5:2]) | ext0), .run1((|oe[1:0]) | ext1),
      .sense0(s0), .sense1(s1));

   // --------
   // checks and bus
   // --------
   task automatic end_of_test();
      $display("checks %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : end_of_test

   task automatic hang();
      num_errors++;
      $display("unexpected at %0t: wait ran out", $time);
      end_of_test();
   endtask : hang

   task automatic chk(input logic [31:0] got, input logic [31:0] x);
      samples_checked++;
      if (got !== x)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, x);
      end
   endtask : chk

   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      samples_checked++;
      if ((got >= lo && got <= hi) !== 1'b1)
      begin
         num_errors++;
         $display("unexpected at %0t: got %h outside %h..%h", $time, got, lo, hi);
      end
   endtask : chk_rng

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clock);
         n++;
      end
      while (pready !== 1'b1 && n < 64);
      if (n >= 64)
         hang();
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h00000000);
      chk(q, x);
   endtask : rdc

   // one conversion, watching the pins until the interrupt
   task automatic conv(input logic [3:0] m, input logic s, input logic [19:0] rp, input logic [13:0] op,
                       input logic [5:0] x);
      int   c;
      logic both;
      wr(`RCA_OFS_REF, {12'h000, rp});
      wr(`RCA_OFS_OSC, {18'h00000, op});
      wr(`RCA_OFS_MODE, {28'h0000000, m});
      ext0 <= (m == 4'h0);
      ext1 <= (m == 4'h7);
      wr(`RCA_OFS_RUN, {30'h00000000, s, 1'b1});
      c = 0;
      both = 1'b0;
      while (irq !== 1'b1)
      begin
         @(negedge clock);
         c++;
         both |= (|oe[5:2]) & (|oe[1:0]);
         if (c == 10)
         begin
            chk(oe, x);
            if ($countones(x) == 2)
               chk(^(po & x), 1'b1);
         end
         if (c > 3000)
            hang();
      end
      ncyc = c;
      chk(both, 1'b0);
      @(posedge clock);
      ext0 <= 1'b0;
      ext1 <= 1'b0;
   endtask : conv

   // --------
   // scenarios
   // --------
   task automatic s_reset();
      rdc(`RCA_OFS_RUN, 32'h00000000);
      rdc(`RCA_OFS_MODE, 32'h00000000);
      rdc(`RCA_OFS_REF, 32'h00000000);
      rdc(`RCA_OFS_OSC, 32'h00000000);
      rdc(`RCA_OFS_STS, 32'h00000000);
      rdc(`RCA_OFS_INFO, 32'h0000002F);
      apb(1'b0, 8'h40, 32'h00000000);
      chk(e, 1'b1);
      chk(q, 32'h00000000);
      chk(irq, 1'b0);
   endtask : s_reset

   task automatic s_idle();
      wr(`RCA_OFS_MASK, 32'h00000001);
      wr(`RCA_OFS_REF, 32'h00012345);
      wr(`RCA_OFS_MODE, 32'h00000001);
      repeat (20) @(posedge clock);
      chk(oe, 6'h00);
      rdc(`RCA_OFS_REF, 32'h00012345);
      rdc(`RCA_OFS_MODE, 32'h00000001);
      rdc(`RCA_OFS_MASK, 32'h00000001);
   endtask : s_idle

   task automatic s_modes();
      for (int m = 0; m < 10; m++)
      begin
         conv((m == 9) ? 4'hF : 4'(m), 1'b0, 20'h79900, 14'h0000, xoe_tab[m]);
         chk_rng(ncyc, 32'h00000063, 32'h00000067);
         rdc(`RCA_OFS_RUN, 32'h00000000);
         chk(oe, 6'h00);
         rdc(`RCA_OFS_REF, 32'h00000000);
         apb(1'b0, `RCA_OFS_OSC, 32'h00000000);
         chk_rng(q, (m < 8) ? 32'h00000009 : 32'h0, (m < 8) ? 32'h0000000E : 32'h0);
         rdc(`RCA_OFS_STS, 32'h00000003);
         wr(`RCA_OFS_STS, 32'h00000007);
      end
      chk(mon_rises, 32'h00000000);
   endtask : s_modes

   task automatic s_osc_gate();
      logic [31:0] held;
      wr(`RCA_OFS_TEST, 32'h00000001);
      rdc(`RCA_OFS_TEST, 32'h00000001);
      conv(4'h2, 1'b1, 20'h00000, 14'h3FFB, 6'h14);
      rdc(`RCA_OFS_OSC, 32'h00000000);
      apb(1'b0, `RCA_OFS_REF, 32'h00000000);
      held = q;
      chk_rng(q, 32'h00000034, 32'h00000049);
      chk_rng(q[3:0], 32'h0, 32'h9);
      rdc(`RCA_OFS_STS, 32'h00000005);
      rdc(`RCA_OFS_RUN, 32'h00000002);
      chk_rng(mon_rises, 32'h3, 32'h8);
      repeat (20) @(posedge clock);
      rdc(`RCA_OFS_REF, held);
      wr(`RCA_OFS_TEST, 32'h00000000);
      wr(`RCA_OFS_STS, 32'h00000007);
   endtask : s_osc_gate

   task automatic s_ovf_irq();
      conv(4'h1, 1'b0, 20'h79900, 14'h3FFE, 6'h24);
      chk_rng(ncyc, 32'h00000063, 32'h00000067);
      rdc(`RCA_OFS_STS, 32'h00000007);
      wr(`RCA_OFS_MASK, 32'h00000000);
      chk(irq, 1'b0);
      wr(`RCA_OFS_MASK, 32'h00000006);
      chk(irq, 1'b1);
      wr(`RCA_OFS_STS, 32'h00000006);
      chk(irq, 1'b0);
      rdc(`RCA_OFS_STS, 32'h00000001);
   endtask : s_ovf_irq

   initial
   begin
      repeat (6) @(posedge clock);
      rstn <= 1'b1;
      @(posedge clock);
      s_reset();
      s_idle();
      s_modes();
      s_osc_gate();
      s_ovf_irq();
      end_of_test();
   end
endmodule : rca_top_tb
`default_nettype wire
